// [sdh_pkg.sv]
`default_nettype none
package sdh_pkg;
  // ***********************
  // register byte addresses
  // ***********************
  localparam logic [31:0] OFS_CLK_DIV  = 32'h4600_0004;
  localparam logic [31:0] OFS_ARG      = 32'h4600_0008;
  localparam logic [31:0] OFS_CTL      = 32'h4600_000c;
  localparam logic [31:0] OFS_STA      = 32'h4600_0010;
  localparam logic [31:0] OFS_RSP0     = 32'h4600_0014;
  localparam logic [31:0] OFS_RSP1     = 32'h4600_0018;
  localparam logic [31:0] OFS_RSP2     = 32'h4600_001c;
  localparam logic [31:0] OFS_RSP3     = 32'h4600_0020;
  localparam logic [31:0] OFS_TIMER    = 32'h4600_0024;
  localparam logic [31:0] OFS_BLEN     = 32'h4600_0028;
  // ***********************
  // field positions
  // ***********************
  localparam int CTL_ABORT    = 12;
  localparam int CTL_CARRIES_TRANSFER_SELECT = 11;
  localparam int CTL_LONG     = 10;
  localparam int CTL_WAIT     = 9;
  localparam int CTL_GO       = 8;
  localparam int STA_CRC      = 12;
  localparam int STA_SENT     = 11;
  localparam int STA_TOUT     = 10;
  localparam int STA_FIN      = 9;
  localparam int STA_ACTIVE   = 8;
  // ***********************
  // reset values and counts
  // ***********************
  localparam logic [7:0]  CLK_DIV_RESET    = 8'h01;
  localparam logic [22:0] TIMEOUT_RESET    = 23'h10000;
  localparam logic [6:0]  REPLY_WAIT_CLKS  = 7'h40;
  localparam logic [7:0]  CMD_FRAME_BITS   = 8'h30;
  localparam logic [7:0]  SHORT_REPLY_BITS = 8'h30;
  localparam logic [7:0]  LONG_REPLY_BITS  = 8'h88;
  localparam logic [7:0]  SHORT_CRC_END    = 8'h28;
  localparam logic [7:0]  LONG_CRC_START   = 8'h08;
  localparam logic [7:0]  LONG_CRC_END     = 8'h80;
  // ***********************
  // types
  // ***********************
  typedef enum logic [1:0] {CS_IDLE, CS_SEND, CS_WAIT, CS_RECV} sdh_cmd_state_e;
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } sdh_bus_req_s;
  typedef struct packed {
    logic abort;
    logic with_data;
  } sdh_cmd_attr_s;
endpackage
`default_nettype wire

// [sdh_cmd_path.sv]
// The plain strobed port was left to the implementer.
`default_nettype none
// What this block does
// - card clock is core clock divided by prescale plus one; prescale resets to one.
// - 32-bit argument register, reset zero, sent with next command.
// - abort-type bit marks the issued command as an abort command.
// - with-data bit marks the issued command as carrying a transfer.
// - long-reply bit selects a 136-bit reply instead of 48-bit.
// - reply is awaited only when expect-reply bit is one.
// - writing one to command_go while idle starts a command; bit clears itself.
// - 8-bit command number field heads the transmitted frame.
// - reply checksum failure sets a sticky flag.
// - end of command transmission sets command-done flag.
// - no reply start within 64 card clocks sets timeout flag.
// - fully received reply sets reply-complete flag.
// - writing one clears a status flag; zero leaves it.
// - read-only active bit is one while command line is busy.
// - reply number captured as 8 bits: start bits plus 6-bit index.
// - word 0 holds status 39:8 short, 127:96 long.
// - word 1 top byte holds checksum byte short, status 95:88 long.
// - long reply fills word 1 low bits 87:64 and word 2 63:32.
// - long reply fills word 3 with remaining 32 bits.
// - 23-bit transfer timeout period held for the data path.
// - 12-bit block length used in block mode, ignored in stream mode.
module sdh_cmd_path (
  input  wire logic                 core_clk_i,
  input  wire logic                 rst_i,
  input  wire logic                 ce_i,
  input  wire sdh_pkg::sdh_bus_req_s bus_i,
  output logic [31:0]               rdata_o,
  output logic                      card_serial_clock_o,
  input  wire logic                 cmd_i,
  output logic                      cmd_o,
  output logic                      cmd_oe_o,
  input  wire logic                 block_mode_i,
  output logic [11:0]               block_length_bytes_o,
  output logic [22:0]               transfer_timeout_count_o,
  output sdh_pkg::sdh_cmd_attr_s    cmd_attr_o,
  output logic                      command_line_active_o
);
  import sdh_pkg::*;

  // ***********************
  // state
  // ***********************
  typedef struct packed {
    logic [7:0]     pre;
    logic [31:0]    arg;
    logic           abort;
    logic           with_data;
    logic           long_sel;
    logic           wait_sel;
    logic           go;
    logic [7:0]     idx;
    logic           f_crc;
    logic           f_sent;
    logic           f_tout;
    logic           f_fin;
    logic [7:0]     rnum;
    logic [31:0]    rsp0;
    logic [31:0]    rsp1;
    logic [31:0]    rsp2;
    logic [31:0]    rsp3;
    logic [22:0]    dtimer;
    logic [11:0]    blen;
    logic [11:0]    blen_out;
    logic [7:0]     div_cnt;
    logic           sclk;
    sdh_cmd_state_e fsm;
    logic [47:0]    frame;
    logic [7:0]     bits;
    logic [135:0]   rx;
    logic [7:0]     rxi;
    logic           rx_long;
    logic [6:0]     crc;
    logic [6:0]     tcnt;
    logic           pin_o;
    logic           pin_oe;
    sdh_cmd_attr_s  attr;
    logic [31:0]    rdata;
  } sdh_state_s;

  sdh_state_s s;
  sdh_state_s next_s;

  // ***********************
  // functions
  // ***********************
  // checksum polynomial x^7 + x^3 + 1, one bit at a time
  function automatic logic [6:0] crc7_step(input logic [6:0] c, input logic b);
    logic       fb;
    logic [6:0] r;
    fb   = b ^ c[6];
    r    = {c[5:0], fb};
    r[3] = c[2] ^ fb;
    return r;
  endfunction

  function automatic logic [6:0] crc7_of40(input logic [39:0] v);
    logic [6:0] c;
    c = 7'h00;
    for (int i = 39; i >= 0; i--) begin
      c = crc7_step(c, v[i]);
    end
    return c;
  endfunction

  function automatic logic [31:0] flag_bits(input sdh_state_s t);
    logic [31:0] r;
    r             = 32'h0000_0000;
    r[STA_CRC]    = t.f_crc;
    r[STA_SENT]   = t.f_sent;
    r[STA_TOUT]   = t.f_tout;
    r[STA_FIN]    = t.f_fin;
    r[STA_ACTIVE] = (t.fsm != CS_IDLE);
    r[7:0]        = t.rnum;
    return r;
  endfunction

  // ***********************
  // next state
  // ***********************
  always_comb begin
    logic         rise;
    logic         fall;
    logic [7:0]   cnt_n;
    logic [135:0] rxv;
    logic         in_crc;
    logic [7:0]   total;
    logic [31:0]  ctl_rd;
    rise   = 1'b0;
    fall   = 1'b0;
    cnt_n  = 8'h00;
    rxv    = '0;
    in_crc = 1'b0;
    total  = 8'h00;
    ctl_rd = 32'h0000_0000;
    next_s = s;

    // divider: high for the first half of each pre+1 period
    rise  = (s.div_cnt == s.pre);
    fall  = (s.div_cnt == (s.pre >> 1));
    cnt_n = rise ? 8'h00 : s.div_cnt + 8'h01;
    next_s.div_cnt = cnt_n;
    next_s.sclk    = (cnt_n <= (s.pre >> 1));

    // register reads, data stands in the next cycle only
    ctl_rd[CTL_ABORT]    = s.abort;
    ctl_rd[CTL_CARRIES_TRANSFER_SELECT] = s.with_data;
    ctl_rd[CTL_LONG]     = s.long_sel;
    ctl_rd[CTL_WAIT]     = s.wait_sel;
    ctl_rd[CTL_GO]       = s.go;
    ctl_rd[7:0]          = s.idx;
    next_s.rdata = 32'h0000_0000;
    if (bus_i.rd) begin
      unique case (bus_i.addr)
        OFS_CLK_DIV: next_s.rdata = {24'h00_0000, s.pre};
        OFS_ARG:     next_s.rdata = s.arg;
        OFS_CTL:     next_s.rdata = ctl_rd;
        OFS_STA:     next_s.rdata = flag_bits(s);
        OFS_RSP0:    next_s.rdata = s.rsp0;
        OFS_RSP1:    next_s.rdata = s.rsp1;
        OFS_RSP2:    next_s.rdata = s.rsp2;
        OFS_RSP3:    next_s.rdata = s.rsp3;
        OFS_TIMER:   next_s.rdata = {9'h000, s.dtimer};
        OFS_BLEN:    next_s.rdata = {20'h0_0000, s.blen};
        default:     next_s.rdata = 32'h0000_0000;
      endcase
    end

    // register writes
    if (bus_i.wr) begin
      unique case (bus_i.addr)
        OFS_CLK_DIV: next_s.pre = bus_i.wdata[7:0];
        OFS_ARG:     next_s.arg = bus_i.wdata;
        OFS_CTL: begin
          next_s.abort     = bus_i.wdata[CTL_ABORT];
          next_s.with_data = bus_i.wdata[CTL_CARRIES_TRANSFER_SELECT];
          next_s.long_sel  = bus_i.wdata[CTL_LONG];
          next_s.wait_sel  = bus_i.wdata[CTL_WAIT];
          next_s.idx       = bus_i.wdata[7:0];
          // a start while busy is dropped, not queued
          if (s.fsm == CS_IDLE) begin
            next_s.go = bus_i.wdata[CTL_GO];
          end
        end
        OFS_STA: begin
          // write one clears; hardware sets below win
          if (bus_i.wdata[STA_CRC]) next_s.f_crc = 1'b0;
          if (bus_i.wdata[STA_SENT]) next_s.f_sent = 1'b0;
          if (bus_i.wdata[STA_TOUT]) next_s.f_tout = 1'b0;
          if (bus_i.wdata[STA_FIN]) next_s.f_fin = 1'b0;
        end
        OFS_TIMER:   next_s.dtimer = bus_i.wdata[22:0];
        OFS_BLEN:    next_s.blen = bus_i.wdata[11:0];
        default: ;
      endcase
    end

    // stream mode hides the block length from the data path
    next_s.blen_out = block_mode_i ? s.blen : 12'h000;

    // command sequencer
    unique case (s.fsm)
      CS_IDLE: begin
        if (s.go) begin
          next_s.go    = 1'b0;
          next_s.frame = {s.idx, s.arg, crc7_of40({s.idx, s.arg}), 1'b1};
          next_s.bits  = CMD_FRAME_BITS;
          next_s.attr.abort     = s.abort;
          next_s.attr.with_data = s.with_data;
          next_s.rx_long = s.long_sel;
          next_s.fsm   = CS_SEND;
        end
      end
      CS_SEND: begin
        // new bit on each falling card clock edge
        if (fall) begin
          if (s.bits != 8'h00) begin
            next_s.pin_o  = s.frame[47];
            next_s.pin_oe = 1'b1;
            next_s.frame  = {s.frame[46:0], 1'b0};
            next_s.bits   = s.bits - 8'h01;
          end else begin
            next_s.pin_o  = 1'b1;
            next_s.pin_oe = 1'b0;
            next_s.f_sent = 1'b1;
            next_s.tcnt   = 7'h00;
            next_s.fsm    = s.wait_sel ? CS_WAIT : CS_IDLE;
          end
        end
      end
      CS_WAIT: begin
        if (rise) begin
          if (!cmd_i) begin
            // start bit seen; it counts toward a short checksum
            next_s.rxi = 8'h01;
            next_s.rx  = '0;
            next_s.crc = s.rx_long ? 7'h00 : crc7_step(7'h00, 1'b0);
            next_s.fsm = CS_RECV;
          end else if (s.tcnt == REPLY_WAIT_CLKS - 7'h01) begin
            next_s.f_tout = 1'b1;
            next_s.fsm    = CS_IDLE;
          end else begin
            next_s.tcnt = s.tcnt + 7'h01;
          end
        end
      end
      CS_RECV: begin
        if (rise) begin
          total  = s.rx_long ? LONG_REPLY_BITS : SHORT_REPLY_BITS;
          rxv    = {s.rx[134:0], cmd_i};
          in_crc = s.rx_long ? (s.rxi >= LONG_CRC_START && s.rxi < LONG_CRC_END)
                             : (s.rxi < SHORT_CRC_END);
          next_s.rx  = rxv;
          next_s.rxi = s.rxi + 8'h01;
          if (in_crc) begin
            next_s.crc = crc7_step(s.crc, cmd_i);
          end
          if (s.rxi == total - 8'h01) begin
            next_s.fsm   = CS_IDLE;
            next_s.f_fin = 1'b1;
            if (s.crc != rxv[7:1]) begin
              next_s.f_crc = 1'b1;
            end
            if (s.rx_long) begin
              next_s.rnum = rxv[135:128];
              next_s.rsp0 = rxv[127:96];
              next_s.rsp1 = rxv[95:64];
              next_s.rsp2 = rxv[63:32];
              next_s.rsp3 = rxv[31:0];
            end else begin
              next_s.rnum = rxv[47:40];
              next_s.rsp0 = rxv[39:8];
              next_s.rsp1 = {rxv[7:0], 24'h00_0000};
              next_s.rsp2 = 32'h0000_0000;
              next_s.rsp3 = 32'h0000_0000;
            end
          end
        end
      end
    endcase
  end

  // ***********************
  // registers
  // ***********************
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s        <= '0;
      s.pre    <= CLK_DIV_RESET;
      s.dtimer <= TIMEOUT_RESET;
      s.sclk   <= 1'b1;
      s.pin_o  <= 1'b1;
    end else if (ce_i) begin
      s <= next_s;
    end
  end

  // ***********************
  // outputs
  // ***********************
  assign rdata_o                  = s.rdata;
  assign card_serial_clock_o      = s.sclk;
  assign cmd_o                    = s.pin_o;
  assign cmd_oe_o                 = s.pin_oe;
  assign block_length_bytes_o     = s.blen_out;
  assign transfer_timeout_count_o = s.dtimer;
  assign cmd_attr_o               = s.attr;
  assign command_line_active_o    = (s.fsm != CS_IDLE);

endmodule
`default_nettype wire

// [sdh_cmd_path_assertions.sv]
`default_nettype none
module sdh_cmd_path_assertions (
  input wire logic                  core_clk_i,
  input wire logic                  rst_i,
  input wire logic                  ce_i,
  input wire sdh_pkg::sdh_bus_req_s bus_i,
  input wire logic [31:0]           rdata_o,
  input wire logic                  card_serial_clock_o,
  input wire logic                  cmd_i,
  input wire logic                  cmd_o,
  input wire logic                  cmd_oe_o,
  input wire logic                  block_mode_i,
  input wire logic [11:0]           block_length_bytes_o,
  input wire logic [22:0]           transfer_timeout_count_o,
  input wire sdh_pkg::sdh_cmd_attr_s cmd_attr_o,
  input wire logic                  command_line_active_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import sdh_pkg::*;
  // ****
  // helpers
  // ****
  logic [8:0]  gap;
  logic        gap_ok;
  logic [7:0]  pre;
  logic [12:0] ctl;
  logic [6:0]  nrise;
  wire logic   pre_wr = ce_i && bus_i.wr && bus_i.addr == OFS_CLK_DIV;
  // first period after a prescale write or a freeze may be odd, so it is skipped
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      gap <= '0;
      gap_ok <= 1'b0;
      pre <= CLK_DIV_RESET;
      ctl <= '0;
      nrise <= '0;
    end else begin
      gap <= $rose(card_serial_clock_o) ? 9'h1 : gap + 9'h1;
      gap_ok <= (pre_wr || !ce_i) ? 1'b0 : gap_ok | $rose(card_serial_clock_o);
      if (pre_wr) pre <= bus_i.wdata[7:0];
      if (ce_i && bus_i.wr && bus_i.addr == OFS_CTL && !command_line_active_o)
        ctl <= bus_i.wdata[12:0];
      nrise <= !cmd_oe_o ? 7'h0 : nrise + 7'($rose(card_serial_clock_o));
    end
  end
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  a_card_clk_period: assert property (gap_ok && $rose(card_serial_clock_o) |->
    gap == {1'b0, pre} + 9'h1) else $error("card clock period wrong");
  a_go_starts_cmd: assert property (ce_i && bus_i.wr && bus_i.addr == OFS_CTL
    && bus_i.wdata[CTL_GO] && !command_line_active_o |-> ##2 command_line_active_o)
    else $error("go not started");
  a_attr_latched: assert property ($rose(command_line_active_o) |-> ##[0:2]
    cmd_attr_o == ctl[12:11]) else $error("attributes not latched");
  a_frame_length: assert property ($fell(cmd_oe_o) |-> nrise == 7'h30)
    else $error("frame not 48 bits");
  a_frame_head: assert property ($rose(cmd_oe_o) |-> cmd_o == ctl[7])
    else $error("frame head wrong");
  a_idle_released: assert property (!command_line_active_o && !$past(command_line_active_o)
    |-> !cmd_oe_o && cmd_o) else $error("line driven while idle");
  a_timeout_load: assert property (ce_i && bus_i.wr && bus_i.addr == OFS_TIMER |=>
    transfer_timeout_count_o == $past(bus_i.wdata[22:0])) else $error("timeout not loaded");
  a_stream_len_zero: assert property (ce_i && !block_mode_i |=> block_length_bytes_o == 12'h0)
    else $error("length shown in stream mode");
  a_freeze_hold: assert property (!ce_i |=>
    $stable(card_serial_clock_o) && $stable(cmd_oe_o) && $stable(rdata_o))
    else $error("state moved while frozen");
  cover property ($fell(cmd_oe_o));
  cover property ($fell(command_line_active_o));
  cover property (block_mode_i && block_length_bytes_o != 12'h0);
endmodule
bind sdh_cmd_path sdh_cmd_path_assertions u_chk (.core_clk_i(core_clk_i), .rst_i(rst_i),
  .ce_i(ce_i), .bus_i(bus_i), .rdata_o(rdata_o), .card_serial_clock_o(card_serial_clock_o),
  .cmd_i(cmd_i), .cmd_o(cmd_o), .cmd_oe_o(cmd_oe_o), .block_mode_i(block_mode_i),
  .block_length_bytes_o(block_length_bytes_o), .cmd_attr_o(cmd_attr_o),
  .transfer_timeout_count_o(transfer_timeout_count_o),
  .command_line_active_o(command_line_active_o));
`default_nettype wire

// [sdh_card_model.sv]
`default_nettype none
module sdh_card_model (
  input  wire logic         sclk_i,
  input  wire logic         rst_i,
  input  wire logic         host_cmd_i,
  input  wire logic         host_oe_i,
  input  wire logic [1:0]   mode_i,
  input  wire logic         bad_i,
  input  wire logic [119:0] body_i,
  output var  logic         drv_o,
  output var  logic         bit_o,
  output var  logic [47:0]  frame_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // card side
  // ****
  function automatic logic [6:0] crc7(input logic [119:0] d, input int n);
    logic [6:0] c;
    logic       fb;
    c = 7'h0;
    for (int i = n - 1; i >= 0; i--) begin
      fb = d[i] ^ c[6];
      c = {c[5:0], fb} ^ {3'h0, fb, 3'h0};
    end
    return c;
  endfunction
  initial begin
    drv_o = 1'b0;
    bit_o = 1'b1;
  end
  always @(posedge sclk_i or posedge rst_i) begin
    if (rst_i) frame_o <= '0;
    else if (host_oe_i) frame_o <= {frame_o[46:0], host_cmd_i};
  end
  // mode 0 stays silent so the host must time out
  always @(negedge host_oe_i) begin : reply
    logic [135:0] r;
    int           n;
    if (mode_i == 2'd1) begin
      r = {88'h0, 2'b00, body_i[37:0], crc7({82'h0, body_i[37:0]}, 40) ^ {6'h0, bad_i}, 1'b1};
      n = 48;
    end else begin
      r = {2'b00, 6'h3f, body_i, crc7(body_i, 120) ^ {6'h0, bad_i}, 1'b1};
      n = 136;
    end
    if (mode_i != 2'd0) begin
      repeat (2) @(negedge sclk_i);
      for (int i = n - 1; i >= 0; i--) begin
        bit_o <= r[i];
        drv_o <= 1'b1;
        @(negedge sclk_i);
      end
      // released: show the inverse so a late sample cannot pass by luck
      drv_o <= 1'b0;
      bit_o <= ~r[0];
    end
  end
endmodule
`default_nettype wire

// [sdh_cmd_path_tb_top.sv]
`default_nettype none
module sdh_cmd_path_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import sdh_pkg::*;
  logic          core_clk_i = 1'b0;
  logic          rst_i = 1'b1;
  logic          block_mode_i = 1'b0;
  logic          ce = 1'b1;
  sdh_bus_req_s  bus_r = '0;
  logic [31:0]   rdata_o;
  logic          sclk, cmd_o, cmd_oe_o, active, drv, cbit;
  logic          rd_pend = 1'b0;
  logic [11:0]   blen_o;
  logic [22:0]   tmr_o;
  sdh_cmd_attr_s attr_o;
  logic [47:0]   frame;
  logic [1:0]    mode = 2'd0;
  logic          bad = 1'b0;
  logic [119:0]  body = '0;
  logic [63:0]   q[$];
  int            errors = 0;
  int            n_tests = 0;
  logic [31:0]   rnd = 32'h5ab5;
  // pulled-up line: nobody driving reads high
  wire logic     cmd_line = cmd_oe_o ? cmd_o : (drv ? cbit : 1'b1);
  sdh_cmd_path dut (.core_clk_i(core_clk_i), .rst_i(rst_i), .ce_i(ce), .bus_i(bus_r),
    .rdata_o(rdata_o), .card_serial_clock_o(sclk), .cmd_i(cmd_line), .cmd_o(cmd_o),
    .cmd_oe_o(cmd_oe_o), .block_mode_i(block_mode_i), .block_length_bytes_o(blen_o),
    .transfer_timeout_count_o(tmr_o), .cmd_attr_o(attr_o), .command_line_active_o(active));
  sdh_card_model card (.sclk_i(sclk), .rst_i(rst_i), .host_cmd_i(cmd_o), .host_oe_i(cmd_oe_o),
    .mode_i(mode), .bad_i(bad), .body_i(body), .drv_o(drv), .bit_o(cbit), .frame_o(frame));
  initial forever #5 core_clk_i = ~core_clk_i;
  // ****
  // tasks
  // ****
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    bus_r <= '{a, d, 1'b1, 1'b0};
    @(posedge core_clk_i);
    bus_r <= '0;
    @(posedge core_clk_i);
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] e, input logic [31:0] m);
    q.push_back({m, e & m});
    bus_r <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge core_clk_i);
    bus_r <= '0;
    @(posedge core_clk_i);
  endtask
  task automatic wait_idle;
    int k = 0;
    repeat (3) @(posedge core_clk_i);
    while (active !== 1'b0 && k < 5000) begin
      @(posedge core_clk_i);
      k++;
    end
    if (k == 5000) begin
      errors++;
      $display("MISMATCH %0t command never ended", $time);
      print_verdict();
    end
  endtask
  always @(posedge core_clk_i) rd_pend <= bus_r.rd;
  always @(negedge core_clk_i) begin : mon
    logic [63:0] n;
    if (rd_pend) begin
      n = q.pop_front();
      chk({32'h0, rdata_o & n[63:32]}, {32'h0, n[31:0]});
    end
  end
  // ****
  // main sequence
  // ****
  initial begin : main
    logic [31:0]  a, arg, ctl, sta;
    logic [7:0]   cmd;
    logic [127:0] lw;
    logic [6:0]   crc;
    repeat (20) @(posedge core_clk_i);
    rst_i <= 1'b0;
    @(posedge core_clk_i);
    wr(32'h4600_002c, 32'hffff_ffff);
    for (a = OFS_CLK_DIV; a <= 32'h4600_002c; a += 32'h4)
      rd(a, a == OFS_CLK_DIV ? 32'h1 : a == OFS_TIMER ? 32'h10000 : 32'h0, '1);
    rnd = lfsr(rnd);
    arg = rnd;
    wr(OFS_ARG, arg);
    wr(OFS_TIMER, rnd);
    wr(OFS_BLEN, {rnd[31:2], 2'b00});
    rd(OFS_ARG, arg, '1);
    rd(OFS_TIMER, {9'h0, rnd[22:0]}, '1);
    rd(OFS_BLEN, {20'h0, rnd[11:2], 2'b00}, '1);
    block_mode_i <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    chk(64'(blen_o), 64'({rnd[11:2], 2'b00}));
    chk(64'(tmr_o), 64'(rnd[22:0]));
    // a write while frozen must not land
    ce <= 1'b0;
    wr(OFS_ARG, ~arg);
    ce <= 1'b1;
    rd(OFS_ARG, arg, '1);
    $display("test registers done");
    for (int c = 0; c < 4; c++) begin
      rnd = lfsr(rnd);
      arg = rnd;
      cmd = {2'b01, rnd[13:8]};
      for (int i = 0; i < 4; i++) begin
        rnd = lfsr(rnd);
        body = {body[87:0], rnd};
      end
      mode = c == 1 ? 2'd1 : c == 2 ? 2'd2 : 2'd0;
      bad = c == 2;
      ctl = {19'h0, c[0] == 0, c[0] ^ c[1], c == 2, c != 0, 1'b1, cmd};
      wr(OFS_CLK_DIV, c == 1 ? 32'h3 : c == 3 ? 32'h2 : 32'h1);
      wr(OFS_ARG, arg);
      wr(OFS_CTL, ctl);
      rd(OFS_STA, 32'h100, 32'h100);
      wait_idle();
      crc = card.crc7({80'h0, cmd, arg}, 40);
      chk(64'(frame), {16'h0, cmd, arg, crc, 1'b1});
      chk(64'(attr_o), {62'h0, ctl[12:11]});
      rd(OFS_CTL, ctl & ~32'h100, '1);
      lw = c == 1 ? {body[31:0], card.crc7({82'h0, body[37:0]}, 40), 1'b1, 88'h0}
                  : {body, card.crc7(body, 120) ^ {6'h0, bad}, 1'b1};
      if (c == 1 || c == 2)
        for (int w = 0; w < 4; w++)
          rd(OFS_RSP0 + 32'(4 * w), lw[127 - 32 * w -: 32], '1);
      sta = {19'h0, c == 2, 1'b1, c == 3, c == 1 || c == 2, 1'b0,
             (c == 1 ? {2'b00, body[37:32]} : c >= 2 ? 8'h3f : 8'h00)};
      rd(OFS_STA, sta, 32'hffff_ffff);
      wr(OFS_STA, 32'h0);
      rd(OFS_STA, sta, 32'h1f00);
      wr(OFS_STA, 32'h1e00);
      rd(OFS_STA, 32'h0, 32'h1f00);
      $display("test command %0d done", c);
    end
    repeat (3) @(posedge core_clk_i);
    print_verdict();
  end
endmodule
`default_nettype wire
